// >>> pkg/apl_pkg.sv
// Constants and types shared by the alarm panel and loopback control block.
package apl_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] FAR_OFF  = 12'h008;

    // Control register layout and reset value.
    localparam int unsigned CTRL_W               = 4;
    localparam int unsigned CTRL_MAIN_ALM_DIS    = 0;
    localparam int unsigned CTRL_WAY_ALM_DIS     = 1;
    localparam int unsigned CTRL_MAIN_EXT_PAT    = 2;
    localparam int unsigned CTRL_ERR_FLASH       = 3;
    localparam logic [3:0]  CTRL_RESET           = 4'h0;

    // Indicator vector positions, shared by local and far-end status.
    localparam int unsigned IND_W       = 8;
    localparam int unsigned IND_MAIN_IN = 0;
    localparam int unsigned IND_WAY_IN  = 1;
    localparam int unsigned IND_BER     = 2;
    localparam int unsigned IND_LOCK    = 3;
    localparam int unsigned IND_AIS     = 4;
    localparam int unsigned IND_FAN     = 5;
    localparam int unsigned IND_HW      = 6;
    localparam int unsigned IND_ERROR   = 7;

    // Channel indices.
    localparam int unsigned CH_MAIN = 0;
    localparam int unsigned CH_WAY  = 1;

    // Timing in microseconds and the clock rate in MHz.
    localparam longint unsigned CLK_MHZ       = 200;
    localparam longint unsigned DEBOUNCE_US   = 10000;
    localparam longint unsigned LB_HOLD_US    = 3000000;
    localparam longint unsigned BLINK_HALF_US = 250000;
    localparam longint unsigned RAPID_HALF_US = 62500;
    localparam longint unsigned ERR_FLASH_US  = 50000;
    localparam longint unsigned DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
    localparam longint unsigned LB_HOLD_CYC   = LB_HOLD_US * CLK_MHZ;
    localparam longint unsigned BLINK_CYC     = BLINK_HALF_US * CLK_MHZ;
    localparam longint unsigned RAPID_CYC     = RAPID_HALF_US * CLK_MHZ;
    localparam longint unsigned ERR_FLASH_CYC = ERR_FLASH_US * CLK_MHZ;

    // Error-rate measurement window and tolerated errors per window.
    localparam longint unsigned BER_WINDOW_BITS = 1000000;
    localparam logic [31:0]     BER_ERR_LIMIT   = 32'h0000_0001;

    // Loopback state of one channel.
    typedef enum logic [1:0] {LB_IDLE, LB_NEAR, LB_FAR} apl_lb_state_type;

endpackage : apl_pkg

// >>> logic/apl_button.sv
// Debounce and hold-time measurement for one front-panel push-button.
`timescale 1ns/1ps
module apl_button #(
    parameter int unsigned DEB_CYC  = 32'(apl_pkg::DEBOUNCE_CYC),
    parameter int unsigned HOLD_CYC = 32'(apl_pkg::LB_HOLD_CYC)
) (
    // Clock and reset.
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    // Raw button, high while pressed.
    input  wire logic btn_i,
    // Debounced results.
    output logic      level_o,
    output logic      held_o,
    output logic      tap_o
);
    logic [31:0] deb_cnt_q;
    logic [31:0] hold_cnt_q;
    logic        level_q;
    logic        reached_q;

    // A new level must stand for the whole debounce time before it is believed.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            deb_cnt_q <= 32'h0;
            level_q   <= 1'b0;
        end else if (btn_i == level_q) begin
            deb_cnt_q <= 32'h0;
        end else if (deb_cnt_q >= DEB_CYC - 1) begin
            deb_cnt_q <= 32'h0;
            level_q   <= btn_i;
        end else begin
            deb_cnt_q <= deb_cnt_q + 32'h1;
        end
    end

    // Hold time counts clocks of the debounced level; one pulse when reached.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_cnt_q <= 32'h0;
            reached_q  <= 1'b0;
            held_o     <= 1'b0;
            tap_o      <= 1'b0;
        end else begin
            held_o <= level_q && !reached_q && (hold_cnt_q >= HOLD_CYC - 1);
            tap_o  <= !level_q && (hold_cnt_q != 32'h0) && !reached_q;
            if (!level_q) begin
                hold_cnt_q <= 32'h0;
                reached_q  <= 1'b0;
            end else if (!reached_q) begin
                hold_cnt_q <= hold_cnt_q + 32'h1;
                reached_q  <= (hold_cnt_q >= HOLD_CYC - 1);
            end
        end
    end

    assign level_o = level_q;

endmodule : apl_button

// >>> logic/apl_alarm_panel.sv
// Front-panel alarm, status and loopback control with an APB register slave.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module apl_alarm_panel #(
    parameter int unsigned DEB_CYC    = 32'(apl_pkg::DEBOUNCE_CYC),
    parameter int unsigned HOLD_CYC   = 32'(apl_pkg::LB_HOLD_CYC),
    parameter int unsigned BLINK_CYC  = 32'(apl_pkg::BLINK_CYC),
    parameter int unsigned RAPID_CYC  = 32'(apl_pkg::RAPID_CYC),
    parameter int unsigned FLASH_CYC  = 32'(apl_pkg::ERR_FLASH_CYC),
    parameter int unsigned BER_WINDOW = 32'(apl_pkg::BER_WINDOW_BITS)
) (
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // APB slave.
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Operator buttons, high while pressed.
    input  wire logic [1:0]  lb_btn_i,
    input  wire logic        view_btn_i,
    // Line and receiver condition.
    input  wire logic        main_in_present_i,
    input  wire logic        way_in_present_i,
    input  wire logic        rx_lock_i,
    input  wire logic        rx_bit_valid_i,
    input  wire logic        rx_bit_err_i,
    input  wire logic        test_err_i,
    // Health.
    input  wire logic [1:0]  fan_fail_i,
    input  wire logic        hw_fault_i,
    input  wire logic        way_out_short_i,
    // Far-end information and security code.
    input  wire logic        far_valid_i,
    input  wire logic [7:0]  far_status_i,
    input  wire logic [7:0]  far_rsl_i,
    input  wire logic [7:0]  far_security_code_i,
    input  wire logic [1:0]  far_lb_req_i,
    input  wire logic [1:0]  far_lb_clear_i,
    input  wire logic [7:0]  local_rsl_i,
    input  wire logic [7:0]  security_code_switches_i,
    // Indicators.
    output logic [7:0]       indicator_o,
    output logic             far_summary_led_o,
    output logic [1:0]       lb_led_o,
    output logic             view_led_o,
    output logic [7:0]       received_level_output_o,
    // Toward the far end and the data path.
    output logic [7:0]       local_status_o,
    output logic [1:0]       lb_req_o,
    output logic [1:0]       lb_clear_o,
    output logic [1:0]       loop_active_o,
    output logic [1:0]       traffic_off_o,
    output logic             main_int_pattern_o,
    output logic             main_tx_ais_o,
    output logic             way_tx_ais_o,
    output logic             line_ais_o,
    output logic             main_mute_o
);
    logic [3:0]                 ctrl_q;
    logic [2:0]                 btn_level;
    logic [2:0]                 btn_held;
    logic [2:0]                 btn_tap;
    apl_pkg::apl_lb_state_type  lb_state_q [2];
    logic [31:0]                blink_cnt_q;
    logic [31:0]                rapid_cnt_q;
    logic                       blink_q;
    logic                       rapid_q;
    logic [31:0]                ber_bits_q;
    logic [31:0]                ber_errs_q;
    logic                       ber_alarm_q;
    logic                       err_latch_q;
    logic [31:0]                err_flash_q;
    logic                       mismatch;
    logic                       any_near;
    logic [7:0]                 local_vec;
    logic                       view_far;
    logic [1:0]                 far_block_q;

    // Buttons 0 and 1 start loopback, button 2 is the remote-view button.
    generate
        for (genvar b = 0; b < 3; b++) begin : g_btn
            apl_button #(
                .DEB_CYC  (DEB_CYC),
                .HOLD_CYC (HOLD_CYC)
            ) u_btn (
                .sys_clk_i (sys_clk_i),
                .resetn_i  (resetn_i),
                .btn_i     ((b == 2) ? view_btn_i : lb_btn_i[b]),
                .level_o   (btn_level[b]),
                .held_o    (btn_held[b]),
                .tap_o     (btn_tap[b])
            );
        end
    endgenerate

    // Loopback state per channel. A long hold only starts loopback, a short tap only ends it,
    // so the release that follows the starting hold cannot cancel the test it just began.
    generate
        for (genvar c = 0; c < 2; c++) begin : g_lb
            always_ff @(posedge sys_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    lb_state_q[c] <= apl_pkg::LB_IDLE;
                    lb_clear_o[c] <= 1'b0;
                    far_block_q[c] <= 1'b0;
                end else begin
                    lb_clear_o[c] <= 1'b0;
                    // A far request still standing after a local tap is ignored until the far end drops it,
                    // otherwise the stale request would restart the loop the operator just ended.
                    if (!far_lb_req_i[c]) begin
                        far_block_q[c] <= 1'b0;
                    end
                    case (lb_state_q[c])
                        apl_pkg::LB_IDLE: begin
                            if (btn_held[c]) begin
                                lb_state_q[c] <= apl_pkg::LB_NEAR;
                            end else if (far_lb_req_i[c] && !far_block_q[c]) begin
                                lb_state_q[c] <= apl_pkg::LB_FAR;
                            end
                        end
                        apl_pkg::LB_NEAR: begin
                            if (btn_tap[c] || far_lb_clear_i[c]) begin
                                lb_state_q[c] <= apl_pkg::LB_IDLE;
                            end
                        end
                        apl_pkg::LB_FAR: begin
                            if (btn_tap[c]) begin
                                lb_state_q[c] <= apl_pkg::LB_IDLE;
                                lb_clear_o[c] <= 1'b1;
                                far_block_q[c] <= 1'b1;
                            end else if (!far_lb_req_i[c]) begin
                                lb_state_q[c] <= apl_pkg::LB_IDLE;
                            end
                        end
                        default: begin
                            lb_state_q[c] <= apl_pkg::LB_IDLE;
                        end
                    endcase
                end
            end

            // Lamp flashes at the initiator and is steady at the looping end.
            always_ff @(posedge sys_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    lb_led_o[c]      <= 1'b0;
                    lb_req_o[c]      <= 1'b0;
                    loop_active_o[c] <= 1'b0;
                    traffic_off_o[c] <= 1'b0;
                end else begin
                    lb_led_o[c]      <= (lb_state_q[c] == apl_pkg::LB_FAR) ||
                                        ((lb_state_q[c] == apl_pkg::LB_NEAR) && blink_q);
                    lb_req_o[c]      <= (lb_state_q[c] == apl_pkg::LB_NEAR);
                    loop_active_o[c] <= (lb_state_q[c] == apl_pkg::LB_FAR);
                    traffic_off_o[c] <= (lb_state_q[c] != apl_pkg::LB_IDLE);
                end
            end
        end
    endgenerate

    // Two free-running blink rates; rapid is four times the normal rate.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            blink_cnt_q <= 32'h0;
            rapid_cnt_q <= 32'h0;
            blink_q     <= 1'b0;
            rapid_q     <= 1'b0;
        end else begin
            blink_cnt_q <= (blink_cnt_q >= BLINK_CYC - 1) ? 32'h0 : blink_cnt_q + 32'h1;
            rapid_cnt_q <= (rapid_cnt_q >= RAPID_CYC - 1) ? 32'h0 : rapid_cnt_q + 32'h1;
            if (blink_cnt_q >= BLINK_CYC - 1) begin
                blink_q <= !blink_q;
            end
            if (rapid_cnt_q >= RAPID_CYC - 1) begin
                rapid_q <= !rapid_q;
            end
        end
    end

    // Error rate is judged once per window of received bits, so the alarm lags by a window.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ber_bits_q  <= 32'h0;
            ber_errs_q  <= 32'h0;
            ber_alarm_q <= 1'b0;
        end else if (rx_bit_valid_i) begin
            if (ber_bits_q >= BER_WINDOW - 1) begin
                ber_bits_q  <= 32'h0;
                ber_errs_q  <= 32'h0;
                ber_alarm_q <= (ber_errs_q + {31'h0, rx_bit_err_i}) > apl_pkg::BER_ERR_LIMIT;
            end else begin
                ber_bits_q <= ber_bits_q + 32'h1;
                ber_errs_q <= ber_errs_q + {31'h0, rx_bit_err_i};
            end
        end
    end

    // Test errors count only while this end started a loopback; a new loopback clears the latch,
    // but an error arriving in that same cycle still sets it if a near loopback is already running.
    assign any_near = (lb_state_q[0] == apl_pkg::LB_NEAR) || (lb_state_q[1] == apl_pkg::LB_NEAR);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            err_latch_q <= 1'b0;
            err_flash_q <= 32'h0;
        end else begin
            if (any_near && test_err_i) begin
                err_latch_q <= 1'b1;
            end else if (btn_held[0] || btn_held[1]) begin
                err_latch_q <= 1'b0;
            end
            if (any_near && test_err_i) begin
                err_flash_q <= FLASH_CYC;
            end else if (err_flash_q != 32'h0) begin
                err_flash_q <= err_flash_q - 32'h1;
            end
        end
    end

    // Local alarm vector; the security check needs a valid far-end code to compare against.
    assign mismatch = far_valid_i && (far_security_code_i != security_code_switches_i);
    assign view_far = btn_level[2] && far_valid_i;

    always_comb begin
        local_vec                       = 8'h00;
        local_vec[apl_pkg::IND_MAIN_IN] = !main_in_present_i && !ctrl_q[apl_pkg::CTRL_MAIN_ALM_DIS];
        local_vec[apl_pkg::IND_WAY_IN]  = !way_in_present_i && !ctrl_q[apl_pkg::CTRL_WAY_ALM_DIS];
        local_vec[apl_pkg::IND_BER]     = ber_alarm_q;
        local_vec[apl_pkg::IND_LOCK]    = !rx_lock_i;
        local_vec[apl_pkg::IND_AIS]     = mismatch ? rapid_q : !rx_lock_i;
        local_vec[apl_pkg::IND_FAN]     = |fan_fail_i;
        local_vec[apl_pkg::IND_HW]      = hw_fault_i || way_out_short_i;
        local_vec[apl_pkg::IND_ERROR]   = ctrl_q[apl_pkg::CTRL_ERR_FLASH] ? (err_flash_q != 32'h0) : err_latch_q;
    end

    // Indicators and received level follow the far end while the view button is held and the far end is valid.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            indicator_o             <= 8'h00;
            far_summary_led_o       <= 1'b0;
            view_led_o              <= 1'b0;
            received_level_output_o <= 8'h00;
            local_status_o          <= 8'h00;
        end else begin
            indicator_o             <= view_far ? far_status_i : local_vec;
            received_level_output_o <= view_far ? far_rsl_i : local_rsl_i;
            far_summary_led_o       <= far_valid_i && (|far_status_i);
            view_led_o              <= far_valid_i ? btn_level[2] : blink_q;
            local_status_o          <= local_vec;
        end
    end

    // Data path controls. Injection ignores the alarm-disable switches on purpose.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            main_tx_ais_o      <= 1'b0;
            way_tx_ais_o       <= 1'b0;
            line_ais_o         <= 1'b0;
            main_mute_o        <= 1'b0;
            main_int_pattern_o <= 1'b0;
        end else begin
            main_tx_ais_o      <= !main_in_present_i;
            way_tx_ais_o       <= !way_in_present_i;
            line_ais_o         <= !rx_lock_i;
            main_mute_o        <= mismatch;
            main_int_pattern_o <= (lb_state_q[apl_pkg::CH_MAIN] == apl_pkg::LB_NEAR) &&
                                  !ctrl_q[apl_pkg::CTRL_MAIN_EXT_PAT];
        end
    end

    // APB slave: answer is prepared in the setup cycle so pready and data come from flops.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (psel_i && !penable_i) begin
            pready_o  <= 1'b1;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
            if (paddr_i == apl_pkg::CTRL_OFF) begin
                prdata_o <= {28'h0, ctrl_q};
            end else if (paddr_i == apl_pkg::STAT_OFF) begin
                prdata_o <= {12'h0, 2'(lb_state_q[1]), 2'(lb_state_q[0]), mismatch, view_far,
                             btn_level[2], !far_valid_i, 4'h0, local_vec};
            end else if (paddr_i == apl_pkg::FAR_OFF) begin
                prdata_o <= {7'h0, far_valid_i, far_security_code_i, far_rsl_i, far_status_i};
            end else begin
                pslverr_o <= 1'b1;
            end
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // Control register write takes effect on the completing access edge.
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= apl_pkg::CTRL_RESET;
        end else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o &&
                     paddr_i == apl_pkg::CTRL_OFF) begin
            ctrl_q <= pwdata_i[3:0];
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_hold_done(int c);
        btn_held[c] && lb_state_q[c] == apl_pkg::LB_IDLE;
    endsequence

    a_main_lb_start: assert property (s_hold_done(0) |=> lb_state_q[0] == apl_pkg::LB_NEAR)
        else $error("main loopback did not start after hold");
    a_lb_needs_hold: assert property ($rose(lb_state_q[1] == apl_pkg::LB_NEAR) |-> $past(btn_held[1]))
        else $error("wayside loopback started without hold");
    a_far_lamp_steady: assert property (lb_state_q[0] == apl_pkg::LB_FAR [*2] |=> lb_led_o[0])
        else $error("far-end loopback lamp not steady");
    a_tap_ends_loop: assert property (lb_state_q[1] == apl_pkg::LB_FAR && btn_tap[1]
                                      |=> lb_state_q[1] == apl_pkg::LB_IDLE && lb_clear_o[1])
        else $error("tap did not end loopback");
    a_traffic_cut: assert property (lb_state_q[0] != apl_pkg::LB_IDLE |=> traffic_off_o[0])
        else $error("traffic not cut during loopback");
    a_tx_ais_inject: assert property (!main_in_present_i |=> main_tx_ais_o)
        else $error("alarm signal not injected on main input loss");
    a_line_ais_lock: assert property (!rx_lock_i |=> line_ais_o)
        else $error("line alarm signal missing on lock loss");
    a_mute_mismatch: assert property (mismatch |=> main_mute_o)
        else $error("mismatch did not mute main data");
    a_mismatch_flash: assert property (mismatch && !view_far |=> indicator_o[4] == $past(rapid_q))
        else $error("mismatch lamp not flashing");
    a_clear_idle: assert property (lb_clear_o[1] |=> lb_state_q[1] == apl_pkg::LB_IDLE)
        else $error("far loopback restarted after local tap");
    a_fan_alarm: assert property (!view_far && fan_fail_i != 2'b00 |=> indicator_o[5])
        else $error("fan alarm missing");
    a_view_far: assert property (view_far |=> indicator_o == $past(far_status_i)
                                 && received_level_output_o == $past(far_rsl_i))
        else $error("remote view not showing far values");
    a_int_pattern: assert property (lb_state_q[0] != apl_pkg::LB_NEAR |=> !main_int_pattern_o)
        else $error("internal pattern outside main loopback");

endmodule : apl_alarm_panel

// >>> test/apl_far_end.sv
// Far-end radio model: status, level, code and loopback requests.
`timescale 1ns/1ps
module apl_far_end (
    // Clock and bench commands.
    input  wire logic       sys_clk_i,
    input  wire logic       up_i,
    input  wire logic [7:0] stat_i,
    input  wire logic [1:0] hold_i,
    input  wire logic [1:0] tap_i,
    input  wire logic [1:0] near_clear_i,
    // Far-end view toward the near end.
    output logic            far_valid_o,
    output logic [7:0]      far_status_o,
    output logic [7:0]      far_rsl_o,
    output logic [7:0]      far_code_o,
    output logic [1:0]      far_lb_req_o,
    output logic [1:0]      far_lb_clear_o
);
    logic [7:0] junk_q = 8'h00;
    logic [1:0] cut_q  = 2'b00;
    // A dead link shows changing garbage on status and level, so stale values cannot pass for real ones.
    always_ff @(posedge sys_clk_i) begin
        junk_q         <= junk_q + 8'h35;
        far_valid_o    <= up_i;
        far_status_o   <= up_i ? stat_i : junk_q;
        far_rsl_o      <= up_i ? 8'h5a : ~junk_q;
        far_code_o     <= 8'h81;
        cut_q          <= (cut_q | near_clear_i) & hold_i; // A near tap drops the request until the hold ends.
        far_lb_req_o   <= hold_i & ~(cut_q | near_clear_i);
        far_lb_clear_o <= tap_i;
    end
endmodule : apl_far_end

// >>> test/tb_top.sv
// Self-checking bench for the alarm panel block.
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, view = 0, up = 0, terr = 0, pr, pe, err, fv, mute, mint;
    logic m_in = 1, w_in = 1, lock = 1, hw = 0, shrt = 0, bv = 0, be = 0;
    logic [1:0] lb = 0, fan = 0, fh = 0, ft = 0, fr, fc, req, act, led, toff, clr;
    logic [7:0] st = 0, fs, fl, fcd, ind, lvl, lst, sec = 8'h81;
    logic [11:0] pa = 0;
    logic [31:0] pw = 0, prd, rd;
    logic mtx, wtx, lais, vled, fsum;
    wire logic [5:0] mon = {ind[4], vled, led, act[1], req[0]};
    int tests_run = 0, mismatches = 0, cyc = 0;
    logic [8:0] row_in [8] = '{9'h070, 9'h030, 9'h090, 9'h060, 9'h074, 9'h07c, 9'h072, 9'h151};
    logic [9:0] row_ex [8] = '{10'h000, 10'h081, 10'h182, 10'h218, 10'h020, 10'h020, 10'h040, 10'h140};
    apl_far_end far (.sys_clk_i(clk), .up_i(up), .stat_i(st), .hold_i(fh), .tap_i(ft), .far_valid_o(fv),
        .far_status_o(fs), .far_rsl_o(fl), .far_code_o(fcd), .far_lb_req_o(fr), .far_lb_clear_o(fc),
        .near_clear_i(clr));
    apl_alarm_panel #(.DEB_CYC(4), .HOLD_CYC(20), .BLINK_CYC(8), .RAPID_CYC(2), .FLASH_CYC(4), .BER_WINDOW(16)) dut (
        .sys_clk_i(clk), .resetn_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
        .pwdata_i(pw), .prdata_o(prd), .pready_o(pr), .pslverr_o(pe), .lb_btn_i(lb), .view_btn_i(view),
        .main_in_present_i(m_in), .way_in_present_i(w_in), .rx_lock_i(lock), .rx_bit_valid_i(bv),
        .rx_bit_err_i(be), .test_err_i(terr), .fan_fail_i(fan), .hw_fault_i(hw), .way_out_short_i(shrt),
        .far_valid_i(fv), .far_status_i(fs), .far_rsl_i(fl), .far_security_code_i(fcd), .far_lb_req_i(fr),
        .far_lb_clear_i(fc), .local_rsl_i(8'h3c), .security_code_switches_i(sec), .indicator_o(ind),
        .far_summary_led_o(fsum), .lb_led_o(led), .view_led_o(vled), .received_level_output_o(lvl),
        .local_status_o(lst), .lb_req_o(req), .lb_clear_o(clr), .loop_active_o(act), .traffic_off_o(toff),
        .main_int_pattern_o(mint), .main_tx_ais_o(mtx), .way_tx_ais_o(wtx), .line_ais_o(lais), .main_mute_o(mute));
    // Clock at 200 MHz.
    initial forever #2.5 clk = ~clk;
    task end_sim;
        $display("tests %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // A hung handshake ends the run as a failure.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            $display("[FAIL] %0t timeout", $time);
            mismatches++;
            end_sim();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk) {psel, pen, pwr, pa, pw} <= {2'b10, w, a, d};
        @(posedge clk) pen <= 1;
        do @(posedge clk); while (pr !== 1'b1);
        {rd, err} = {prd, pe};
        {psel, pen} <= 2'b00;
    endtask : apb
    task wt(input int k, input logic v);
        repeat (60) if (mon[k] !== v) @(posedge clk);
        chk(mon[k], v);
    endtask : wt
    task seen(input int k, input logic [1:0] e);
        logic [1:0] s;
        s = 0;
        repeat (32) begin
            @(posedge clk);
            s[mon[k]] = 1'b1;
        end
        chk(s, e);
    endtask : seen
    task press(input int b);
        @(posedge clk) lb[b] <= 1;
        repeat (10) @(posedge clk);
        lb[b] <= 0;
    endtask : press
    // One window of sixteen received bits, the first n of them in error.
    task ber(input int n, input logic e);
        for (int i = 0; i < 16; i++) @(posedge clk) {bv, be} <= {1'b1, i < n};
        @(posedge clk) bv <= 0;
        repeat (2) @(posedge clk);
        chk(ind[2], e);
    endtask : ber
    // Main sequence: registers, alarm rows, then loopback and far-end cases.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        apb(0, 12'h000, 0);
        chk(rd, 0);
        apb(1, 12'h000, 32'hffff_ffff);
        apb(0, 12'h000, 0);
        chk(rd, 32'h0000_000f);
        apb(0, 12'h100, 0);
        chk(err, 1);
        for (int i = 0; i < 8; i++) begin
            apb(1, 12'h000, {30'h0, row_in[i][8:7]});
            {m_in, w_in, lock, fan, hw, shrt} <= row_in[i][6:0];
            repeat (3) @(posedge clk);
            chk({lais, wtx, mtx, ind[6:0]}, row_ex[i]);
            chk(lst[6:0], row_ex[i][6:0]);
            $display("row %0d done", i);
        end
        {w_in, shrt} <= 2'b10;
        ber(2, 1);
        ber(1, 0);
        press(0);
        repeat (30) @(posedge clk);
        chk(req[0], 0);
        lb[0] <= 1;
        wt(0, 1);
        lb[0] <= 0;
        chk({toff[0], mint}, 2'b11);
        apb(0, 12'h004, 0);
        chk(rd, 32'h0001_1000);
        seen(2, 2'b11);
        terr <= 1;
        @(posedge clk) terr <= 0;
        repeat (3) @(posedge clk);
        chk(ind[7], 1);
        press(0);
        wt(0, 0);
        {up, st, fh} <= {1'b1, 8'h24, 2'b10};
        wt(1, 1);
        apb(0, 12'h008, 0);
        chk(rd, 32'h0181_5a24);
        seen(3, 2'b10);
        chk(fsum, 1);
        press(1);
        wt(1, 0);
        repeat (5) @(posedge clk);
        chk(act[1], 0);
        apb(1, 12'h000, 32'h0000_000e);
        lb[0] <= 1;
        wt(0, 1);
        lb[0] <= 0;
        chk(mint, 0);
        terr <= 1;
        @(posedge clk) terr <= 0;
        repeat (2) @(posedge clk);
        chk(ind[7], 1);
        repeat (6) @(posedge clk);
        chk(ind[7], 0);
        ft <= 2'b01;
        @(posedge clk) ft <= 2'b00;
        wt(0, 0);
        $display("loopback done");
        view <= 1;
        repeat (10) @(posedge clk);
        chk({vled, lvl, ind}, 17'h1_5a24);
        sec <= 8'h7e;
        repeat (3) @(posedge clk);
        chk(mute, 1);
        view <= 0;
        repeat (8) @(posedge clk);
        chk(lvl, 8'h3c);
        seen(5, 2'b11);
        up <= 0;
        seen(4, 2'b11);
        $display("far end done");
        rst_n <= 0;
        @(posedge clk) rst_n <= 1;
        chk({mute, vled, ind, act, req}, 0);
        apb(0, 12'h000, 0);
        chk(rd, 0);
        $display("reset done");
        end_sim();
    end
endmodule : tb_top
